// ==== pem_core.sv ====
// Exception state tracking, prioritisation and handler entry for a small core
// Operation
// - Each exception in one of four states
// - Peripheral or software request sets pending
// - Nested handlers both stay active
// - New request while active gives active-pending
// - Reset halts the processor immediately
// - Reset restarts from vector 4 in Thread
// - Nonmaskable interrupt fixed -2, number 2, vector 8
// - Nonmaskable interrupt unmaskable, preempted only by reset
// - Fault exception priority -1, vector 0xC
// - Supervisor call is number 11, vector 0x2C
// - Pendable service request number 14, vector 0x38
// - Timer exception number 15 on zero or software
// - Interrupts from number 16, vectors from 0x40
// - Asynchronous entry may lag triggering instructions
// - Configurable exceptions can be disabled by software
// - Status gives exception number, not interrupt number
// - Priorities 0 to 3, default 0, low wins
// - Equal priority: lowest exception number first
// - Equal priority never preempts, stays pending
// - Entry completion turns pending into active
`timescale 1ns/10ps
`default_nettype none
module pem_core
  import pem_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Asynchronous request pins
  input wire logic [NUM_IRQ-1:0] irqPin,
  input wire logic nmiPin,
  // Synchronous requests from the pipeline and timer
  input wire logic faultEvent,
  input wire logic supervisorCallInstruction,
  input wire logic timerZero,
  input wire logic setPendService,
  input wire logic setPendTimer,
  input wire logic [NUM_IRQ-1:0] setPendIrq,
  // Privileged configuration
  input wire logic [NUM_IRQ-1:0] irqEnable,
  input wire logic enableSupCall,
  input wire logic enablePendService,
  input wire logic enableTimer,
  input wire logic [2*NUM_IRQ-1:0] irqPriority,
  input wire logic [1:0] supCallPriority,
  input wire logic [1:0] pendServicePriority,
  input wire logic [1:0] timerPriority,
  // Pipeline handshake
  input wire logic instructionBoundary,
  input wire logic handlerReturn,
  // Pipeline direction
  output logic pipelineHalt,
  output logic entryStart,
  output logic [31:0] vectorAddress,
  output logic handlerMode,
  output logic [5:0] exceptionNumberStatus,
  output logic [2*NUM_EXC-1:0] exceptionState
);
  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [31:0] vectorOf(input logic [5:0] num);
    vectorOf = VECTOR_BASE + {24'h00_0000, num, 2'b00};
  endfunction

  function automatic logic [2:0] cfgRank(input logic [1:0] prio);
    cfgRank = RANK_CFG_BASE + {1'b0, prio};
  endfunction

  function automatic logic [2:0] rankOf(input logic [3*NUM_EXC-1:0] ranks,
    input logic [5:0] num);
    rankOf = ranks[3*num +: 3];
  endfunction

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  // Pins pass two flops before the edge detect, so a slow edge raises only once
  logic [NUM_IRQ-1:0] irqMeta;
  logic [NUM_IRQ-1:0] irqSync;
  logic nmiMeta;
  logic nmiSync;
  logic nmiLast;
  logic [NUM_IRQ-1:0] irqLast;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irqMeta <= '0;
      irqSync <= '0;
      nmiMeta <= 1'b0;
      nmiSync <= 1'b0;
    end else begin
      irqMeta <= irqPin;
      irqSync <= irqMeta;
      nmiMeta <= nmiPin;
      nmiSync <= nmiMeta;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irqLast <= '0;
      nmiLast <= 1'b0;
    end else begin
      irqLast <= irqSync;
      nmiLast <= nmiSync;
    end
  end

  // ==========================================================
  // Request, enable and rank per exception number
  // ==========================================================
  logic [NUM_EXC-1:0] raise;
  logic [NUM_EXC-1:0] enabled;
  logic [3*NUM_EXC-1:0] rank;

  always_comb begin
    raise = '0;
    enabled = '0;
    rank = {NUM_EXC{RANK_THREAD}};
    raise[EXC_NMI] = nmiSync && !nmiLast;
    enabled[EXC_NMI] = 1'b1;
    rank[3*EXC_NMI +: 3] = RANK_NMI;
    raise[EXC_FAULT] = faultEvent;
    enabled[EXC_FAULT] = 1'b1;
    rank[3*EXC_FAULT +: 3] = RANK_FAULT;
    raise[EXC_SUPCALL] = supervisorCallInstruction;
    enabled[EXC_SUPCALL] = enableSupCall;
    rank[3*EXC_SUPCALL +: 3] = cfgRank(supCallPriority);
    raise[EXC_PENDSRV] = setPendService;
    enabled[EXC_PENDSRV] = enablePendService;
    rank[3*EXC_PENDSRV +: 3] = cfgRank(pendServicePriority);
    raise[EXC_TIMER] = timerZero || setPendTimer;
    enabled[EXC_TIMER] = enableTimer;
    rank[3*EXC_TIMER +: 3] = cfgRank(timerPriority);
    for (int i = 0; i < NUM_IRQ; i++) begin
      // Interrupt i sits at exception number 16 + i
      raise[EXC_IRQ_BASE + i] = (irqSync[i] && !irqLast[i]) || setPendIrq[i];
      enabled[EXC_IRQ_BASE + i] = irqEnable[i];
      rank[3*(EXC_IRQ_BASE + i) +: 3] = cfgRank(irqPriority[2*i +: 2]);
    end
  end

  // ==========================================================
  // Per-exception state
  // ==========================================================
  logic [NUM_EXC-1:0] pending;
  logic [NUM_EXC-1:0] active;
  logic [NUM_EXC-1:0] next_pending;
  logic [NUM_EXC-1:0] next_active;

  // Nesting stack of preempted exception numbers
  // Eight levels cover both fixed levels and all four configurable ones
  logic [5:0] nestStack [0:7];
  logic [2:0] nestDepth;
  logic [5:0] current;
  logic [2:0] currentRank;

  // Entry sequencing
  typedef enum logic [1:0] {
    ST_RUN,
    ST_ENTRY,
    ST_HALT
  } pem_seq_e;
  pem_seq_e seqState;
  logic [1:0] entryCount;
  logic [5:0] entryNum;

  // ==========================================================
  // Arbitration
  // ==========================================================
  logic found;
  logic [5:0] winner;
  logic [2:0] winnerRank;

  pem_arbiter u_arbiter (
    .request(pending & enabled),
    .rank(rank),
    .found(found),
    .winner(winner),
    .winnerRank(winnerRank)
  );

  // Strictly higher priority only: equal rank is left pending
  logic canTake;
  assign canTake = found && (winnerRank < currentRank);

  // Entry completes at the last entry cycle; a better late arrival retargets instead
  logic entryDone;
  logic lateArrival;
  assign lateArrival = (seqState == ST_ENTRY) && canTake && (winnerRank < rankOf(rank, entryNum));
  assign entryDone = (seqState == ST_ENTRY) && (entryCount == ENTRY_LAST) && !lateArrival;

  logic doReturn;
  assign doReturn = (seqState == ST_RUN) && handlerReturn && handlerMode;

  // Entry starts only between instructions and never in the cycle of a return
  logic takeNow;
  assign takeNow = (seqState == ST_RUN) && canTake && instructionBoundary && !doReturn;

  always_comb begin
    next_pending = pending;
    next_active = active;
    if (doReturn) begin
      next_active[current] = 1'b0;
    end
    if (entryDone) begin
      next_pending[entryNum] = 1'b0;
      next_active[entryNum] = 1'b1;
    end
    // A fresh request wins over the clear at entry, giving active and pending
    next_pending = next_pending | raise;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pending <= '0;
    end else begin
      pending <= next_pending;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      active <= '0;
    end else begin
      active <= next_active;
    end
  end

  // ==========================================================
  // Entry sequencer
  // ==========================================================
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      seqState <= ST_HALT;
      entryCount <= 2'h0;
      entryNum <= EXC_RESET;
    end else begin
      case (seqState)
        ST_HALT: begin
          seqState <= ST_RUN;
        end
        ST_RUN: begin
          // Asynchronous sources wait for an instruction boundary
          if (takeNow) begin
            seqState <= ST_ENTRY;
            entryNum <= winner;
            entryCount <= 2'h0;
          end
        end
        ST_ENTRY: begin
          if (lateArrival) begin
            entryNum <= winner;
          end else if (entryDone) begin
            seqState <= ST_RUN;
          end else begin
            entryCount <= entryCount + 2'h1;
          end
        end
        default: begin
          seqState <= ST_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // Nesting of active handlers
  // ==========================================================
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      nestDepth <= 3'h0;
      current <= 6'h00;
      currentRank <= RANK_THREAD;
      for (int i = 0; i < 8; i++) begin
        nestStack[i] <= 6'h00;
      end
    end else if (entryDone) begin
      // Preempted handler stays active underneath
      nestStack[nestDepth] <= current;
      nestDepth <= nestDepth + 3'h1;
      current <= entryNum;
      currentRank <= rankOf(rank, entryNum);
    end else if (doReturn) begin
      if (nestDepth != 3'h0) begin
        nestDepth <= nestDepth - 3'h1;
        current <= nestStack[nestDepth - 3'h1];
        currentRank <= (nestStack[nestDepth - 3'h1] == 6'h00) ?
          RANK_THREAD : rankOf(rank, nestStack[nestDepth - 3'h1]);
      end
    end
  end

  // ==========================================================
  // Outputs to the pipeline
  // ==========================================================
  // Halt covers the whole entry, from the start pulse to the last entry cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pipelineHalt <= 1'b1;
      entryStart <= 1'b0;
    end else begin
      pipelineHalt <= takeNow || ((seqState == ST_ENTRY) && !entryDone);
      entryStart <= takeNow;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      vectorAddress <= VEC_RESET;
    end else if (takeNow || lateArrival) begin
      vectorAddress <= vectorOf(winner);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      handlerMode <= 1'b0;
      exceptionNumberStatus <= 6'h00;
    end else if (entryDone) begin
      handlerMode <= 1'b1;
      exceptionNumberStatus <= entryNum;
    end else if (doReturn) begin
      handlerMode <= (nestDepth > 3'h1);
      exceptionNumberStatus <= (nestDepth != 3'h0) ? nestStack[nestDepth - 3'h1] : 6'h00;
    end
  end

  // Two state bits per exception: {active, pending}
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      exceptionState <= '0;
    end else begin
      for (int i = 0; i < NUM_EXC; i++) begin
        exceptionState[2*i +: 2] <= {next_active[i], next_pending[i]};
      end
    end
  end
endmodule
`default_nettype wire

// ==== pem_pkg.sv ====
// Package of constants and types for the processor exception model
package pem_pkg;
  // Exception numbers
  localparam logic [5:0] EXC_RESET = 6'h01;
  localparam logic [5:0] EXC_NMI = 6'h02;
  localparam logic [5:0] EXC_FAULT = 6'h03;
  localparam logic [5:0] EXC_SUPCALL = 6'h0B;
  localparam logic [5:0] EXC_PENDSRV = 6'h0E;
  localparam logic [5:0] EXC_TIMER = 6'h0F;
  localparam logic [5:0] EXC_IRQ_BASE = 6'h10;
  localparam int NUM_IRQ = 32;
  localparam int NUM_EXC = 48;
  // Vector table
  localparam logic [31:0] VECTOR_BASE = 32'h0000_0000;
  localparam logic [31:0] VEC_RESET = 32'h0000_0004;
  localparam logic [31:0] VEC_NMI = 32'h0000_0008;
  localparam logic [31:0] VEC_FAULT = 32'h0000_000C;
  localparam logic [31:0] VEC_SUPCALL = 32'h0000_002C;
  localparam logic [31:0] VEC_PENDSRV = 32'h0000_0038;
  localparam logic [31:0] VEC_TIMER = 32'h0000_003C;
  localparam logic [31:0] VEC_IRQ_BASE = 32'h0000_0040;
  // Priorities, with a three-bit offset encoding: -3..-1 fixed, 0..3 configurable map to 3..6
  localparam logic [2:0] RANK_RESET = 3'h0;
  localparam logic [2:0] RANK_NMI = 3'h1;
  localparam logic [2:0] RANK_FAULT = 3'h2;
  localparam logic [2:0] RANK_CFG_BASE = 3'h3;
  localparam logic [2:0] RANK_THREAD = 3'h7;
  localparam logic [1:0] PRIO_RESET_VALUE = 2'h0;
  // Handler entry latency in cycles
  localparam int ENTRY_CYCLES = 2;
  localparam logic [1:0] ENTRY_LAST = 2'(ENTRY_CYCLES - 1);

  typedef enum logic [1:0] {
    EXC_INACTIVE,
    EXC_PENDING,
    EXC_ACTIVE,
    EXC_ACTIVE_PENDING
  } pem_state_e;
endpackage

// ==== pem_arbiter.sv ====
// Priority arbiter picking the best pending exception
`timescale 1ns/10ps
`default_nettype none
module pem_arbiter
  import pem_pkg::*;
(
  // Candidates
  input wire logic [NUM_EXC-1:0] request,
  input wire logic [3*NUM_EXC-1:0] rank,
  // Winner
  output logic found,
  output logic [5:0] winner,
  output logic [2:0] winnerRank
);
  // Scan from high number to low so the lowest number wins a tie
  always_comb begin
    found = 1'b0;
    winner = 6'h00;
    winnerRank = RANK_THREAD;
    for (int i = NUM_EXC - 1; i >= 0; i--) begin
      if (request[i] && (rank[3*i +: 3] <= winnerRank)) begin
        found = 1'b1;
        winner = 6'(i);
        winnerRank = rank[3*i +: 3];
      end
    end
  end
endmodule
`default_nettype wire

// ==== pem_monitor.sv ====
// Port-level assertion checker for the exception unit
`timescale 1ns/10ps
`default_nettype none
module pem_monitor
  import pem_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Watched requests and enables
  input wire logic setPendService,
  input wire logic enablePendService,
  // Watched outputs
  input wire logic pipelineHalt,
  input wire logic entryStart,
  input wire logic [31:0] vectorAddress,
  input wire logic handlerMode,
  input wire logic [5:0] exceptionNumberStatus,
  input wire logic [2*NUM_EXC-1:0] exceptionState
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ==========================================
  // Entry sequences
  sequence s_hold;
    pipelineHalt ##1 (pipelineHalt && !entryStart);
  endsequence
  sequence s_done;
    $fell(pipelineHalt) && handlerMode;
  endsequence
  // ==========================================
  // Properties
  property p_rst;
    $fell(sys_rst) |-> pipelineHalt && !handlerMode && vectorAddress == VEC_RESET;
  endproperty
  property p_entry;
    entryStart |-> s_hold;
  endproperty
  property p_vec;
    s_done |-> vectorAddress == {24'h00_0000, exceptionNumberStatus, 2'b00};
  endproperty
  property p_act;
    s_done |-> exceptionState[2*exceptionNumberStatus+1];
  endproperty
  property p_status;
    handlerMode == (exceptionNumberStatus != 6'h00);
  endproperty
  property p_pend;
    setPendService |=> exceptionState[28];
  endproperty
  property p_rsvd;
    exceptionState[21:8] == 14'h0000 && exceptionState[27:24] == 4'h0;
  endproperty
  // Only reset may cut into the nonmaskable handler
  property p_nmi;
    handlerMode && !pipelineHalt && exceptionNumberStatus == EXC_NMI |-> !entryStart;
  endproperty
  property p_dis;
    entryStart && vectorAddress == VEC_PENDSRV |-> enablePendService;
  endproperty
  a_rst: assert property (p_rst) else $error("restart state wrong");
  a_entry: assert property (p_entry) else $error("entry pulse wrong");
  a_vec: assert property (p_vec) else $error("vector wrong");
  a_act: assert property (p_act) else $error("not active");
  a_status: assert property (p_status) else $error("status wrong");
  a_pend: assert property (p_pend) else $error("not pending");
  a_rsvd: assert property (p_rsvd) else $error("reserved used");
  a_nmi: assert property (p_nmi) else $error("nmi preempted");
  a_dis: assert property (p_dis) else $error("disabled taken");
endmodule
bind pem_core pem_monitor i_mon (.*);
`default_nettype wire

// ==== pem_pipe_model.sv ====
// Pipeline model: instruction boundaries and handler returns
`timescale 1ns/10ps
`default_nettype none
module pem_pipe_model (
  // Control from the bench
  input wire logic clock,
  input wire logic slow,
  input wire logic retire,
  // Unit side
  input wire logic pipelineHalt,
  input wire logic handlerMode,
  output logic instructionBoundary,
  output logic handlerReturn
);
  logic [1:0] phase = 2'h0;
  // Returns only from a running handler, never two in a row
  always_ff @(posedge clock) begin
    phase <= phase + 2'h1;
    handlerReturn <= retire && handlerMode && !pipelineHalt && !handlerReturn;
  end
  // Slow mode mimics long instructions that delay entry
  assign instructionBoundary = !slow || phase == 2'h3;
endmodule
`default_nettype wire

// ==== processor_exception_model_tb_top.sv ====
// Self-checking bench for the exception unit
`timescale 1ns/10ps
`default_nettype none
module processor_exception_model_tb_top;
  import pem_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, nmiPin = 1'b0, faultEvent = 1'b0, timerZero = 1'b0;
  logic supervisorCallInstruction = 1'b0, setPendService = 1'b0, setPendTimer = 1'b0;
  logic slow = 1'b0, retire = 1'b0, enableSupCall = 1'b1, enablePendService = 1'b1;
  logic enableTimer = 1'b1;
  logic [31:0] irqPin = 32'h0000_0000, setPendIrq = 32'h0000_0000, irqEnable = 32'hFFFF_FFFF;
  logic [63:0] irqPriority = 64'h0000_0000_0000_0000;
  logic [1:0] supCallPriority = 2'h0, pendServicePriority = 2'h0, timerPriority = 2'h0;
  logic instructionBoundary, handlerReturn, pipelineHalt, entryStart, handlerMode;
  logic [31:0] vectorAddress;
  logic [5:0] exceptionNumberStatus;
  logic [2*NUM_EXC-1:0] exceptionState;
  int num_errors = 0, check_count = 0;
  pem_core i_dut (.*);
  pem_pipe_model i_pipe (.*);
  initial forever #25 clock = ~clock;
  // ==========================================
  // Shared tasks
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (exp !== got) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic waitFor(input bit onEntry);
    for (int i = 0; i < 40; i++) begin
      @(negedge clock);
      if (onEntry ? entryStart === 1'b1 : pipelineHalt === 1'b0) return;
    end
    chk("wait", 32'h1, 32'h0);
    conclude();
  endtask
  task automatic poke(input int k, input logic [31:0] m);
    @(posedge clock);
    case (k)
      0: faultEvent <= 1'b1;
      1: supervisorCallInstruction <= 1'b1;
      2: timerZero <= 1'b1;
      3: setPendService <= 1'b1;
      4: setPendTimer <= 1'b1;
      5: nmiPin <= 1'b1;
      6: irqPin[5] <= 1'b1;
      default: setPendIrq <= m;
    endcase
    @(posedge clock);
    {faultEvent, supervisorCallInstruction, timerZero, setPendService} <= 4'h0;
    {setPendTimer, nmiPin} <= 2'h0;
    irqPin <= 32'h0000_0000;
    setPendIrq <= 32'h0000_0000;
  endtask
  task automatic enter(input logic [5:0] n);
    waitFor(1'b1);
    chk("vector", {24'h00_0000, n, 2'b00}, vectorAddress);
    waitFor(1'b0);
    chk("status", {26'h000_0000, n}, exceptionNumberStatus);
    chk("active", 32'h1, exceptionState[2*n+1]);
  endtask
  task automatic drain;
    @(posedge clock);
    retire <= 1'b1;
    repeat (60) @(posedge clock);
    retire <= 1'b0;
    slow <= ~slow;
    @(negedge clock);
    chk("mode", 32'h0, handlerMode);
    chk("idle", 32'h0, |exceptionState);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(negedge clock);
    chk("halt", 32'h1, pipelineHalt);
    chk("idle", 32'h0, |exceptionState);
    chk("vector", 32'h0000_0004, vectorAddress);
    @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(negedge clock);
    chk("halt", 32'h0, pipelineHalt);
    chk("mode", 32'h0, handlerMode);
    $display("test reset done");
  endtask
  task automatic t_table;
    int ks[8] = '{3, 1, 2, 4, 0, 5, 6, 7};
    logic [5:0] ns[8] = '{6'h0E, 6'h0B, 6'h0F, 6'h0F, 6'h03, 6'h02, 6'h15, 6'h10};
    for (int i = 0; i < 8; i++) begin
      poke(ks[i], 32'h0000_0001);
      enter(ns[i]);
      drain();
    end
    $display("test sources done");
  endtask
  task automatic t_tie;
    poke(7, 32'h0000_000A);
    enter(6'h11);
    poke(7, 32'h0000_0006);
    repeat (6) @(negedge clock);
    chk("status", 32'h11, exceptionNumberStatus);
    chk("irq1", 32'h3, exceptionState[35:34]);
    chk("irq2", 32'h1, exceptionState[37:36]);
    drain();
    $display("test tie done");
  endtask
  task automatic t_nest;
    @(posedge clock);
    irqPriority <= 64'h0000_0000_0000_6003;
    poke(7, 32'h0000_0001);
    enter(6'h10);
    poke(0, 32'h0000_0000);
    enter(6'h03);
    chk("outer", 32'h2, exceptionState[33:32]);
    poke(7, 32'h0000_00C0);
    @(posedge clock);
    retire <= 1'b1;
    @(posedge clock);
    retire <= 1'b0;
    enter(6'h17);
    drain();
    // Later scenarios expect every interrupt back at priority 0
    @(posedge clock);
    irqPriority <= 64'h0000_0000_0000_0000;
    $display("test nest done");
  endtask
  task automatic t_off;
    @(posedge clock);
    irqEnable <= 32'hFFFF_FFEF;
    enablePendService <= 1'b0;
    poke(3, 32'h0000_0000);
    poke(7, 32'h0000_0010);
    repeat (8) @(negedge clock);
    chk("mode", 32'h0, handlerMode);
    chk("held", 32'h1, exceptionState[41:40]);
    @(posedge clock);
    irqEnable <= 32'hFFFF_FFFF;
    enter(6'h14);
    @(posedge clock);
    enablePendService <= 1'b1;
    drain();
    $display("test disable done");
  endtask
  initial begin
    t_reset();
    t_table();
    t_tie();
    t_nest();
    t_off();
    poke(7, 32'h0000_0003);
    enter(6'h10);
    t_reset();
    conclude();
  end
endmodule
`default_nettype wire
